/* File: verilog/adtf_consts.vh */
// Purpose: Constants for the conversion trigger and result format block
// Assumes: 20 MHz system clock, 8-bit register port
// Notes:   Register indices are byte addresses on the plain port
`ifndef ADTF_CONSTS_VH
`define ADTF_CONSTS_VH

// Register addresses
`define ADTF_ADDR_TRIG      4'h0
`define ADTF_ADDR_RES_HI    4'h1
`define ADTF_ADDR_RES_LO    4'h2
`define ADTF_ADDR_CTRL      4'h3
`define ADTF_ADDR_STATUS    4'h4
`define ADTF_ADDR_MASK      4'h5
`define ADTF_ADDR_W         4

// Trigger select register layout
`define ADTF_SEL_HI         7
`define ADTF_SEL_LO         4
`define ADTF_TRIG_RST       8'h00

// Selector codes
`define ADTF_SEL_NONE       4'h0
`define ADTF_SEL_PWM1_INT   4'h1
`define ADTF_SEL_PWM2_INT   4'h2
`define ADTF_SEL_T0_OVF     4'h3
`define ADTF_SEL_T1_OVF     4'h4
`define ADTF_SEL_PERIOD_TIMER_MATCH   4'h5
`define ADTF_SEL_CMP1       4'h6
`define ADTF_SEL_CMP2       4'h7
`define ADTF_SEL_PWM1_OF    4'h8
`define ADTF_SEL_PWM2_OF    4'h9
`define ADTF_SEL_PWM3_OF    4'hA
`define ADTF_SEL_PWM3_INT   4'hB
`define ADTF_SEL_PWM4_OF    4'hC
`define ADTF_SEL_PWM4_INT   4'hD
`define ADTF_SEL_TRIG_PIN   4'hE
`define ADTF_SEL_WAVE_PIN   4'hF
`define ADTF_NUM_SRC        16

// Control register bits
`define ADTF_CTRL_JUSTIFY   0
`define ADTF_CTRL_ENABLE    1
`define ADTF_CTRL_GO        2
`define ADTF_CTRL_BUSY      3
`define ADTF_CTRL_RST       8'h00

// Status and mask bits
`define ADTF_ST_DONE        0
`define ADTF_ST_TRIG        1
`define ADTF_ST_T0OVF       2
`define ADTF_ST_T1OVF       3
`define ADTF_ST_W           4
`define ADTF_ST_RST         4'h0

// Conversion length, time in ns and cycles at 50 ns
`define ADTF_CONV_TIME_NS   550
`define ADTF_CLK_NS         50
`define ADTF_CONV_CYCLES    ((`ADTF_CONV_TIME_NS + `ADTF_CLK_NS - 1) / `ADTF_CLK_NS)
`define ADTF_CNT_W          4

`endif

/* File: verilog/adtf_sync2.v */
// Purpose: Two-stage synchroniser for a bus of pin inputs
// Assumes: Inputs are asynchronous to sys_clk_i
// Notes:   First stage feeds only the second stage
`include "adtf_consts.vh"
module adtf_sync2
#(
    parameter W = 2
)
(
    input  wire         sys_clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] async_i,
    output reg  [W-1:0] sync_o
);

    reg [W-1:0] meta_reg;

    // Two flops per bit
    always @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            meta_reg <= {W{1'b0}};
            sync_o   <= {W{1'b0}};
        end
        else
        begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end

endmodule

/* File: verilog/adtf_edge_sel.v */
// Purpose: Selects one start source and detects its rising edge
// Assumes: All sources are on the system clock domain
// Notes:   Selector change re-arms the edge detector to avoid false edges
`include "adtf_consts.vh"
module adtf_edge_sel
(
    input  wire                     sys_clk_i,
    input  wire                     rst_i,
    input  wire [`ADTF_NUM_SRC-1:0] src_i,
    input  wire [3:0]               sel_i,
    output reg                      rise_o
);

    reg       level_reg;
    reg       prev_reg;
    reg [3:0] sel_prev_reg;

    // Pick the selected source level
    always @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            level_reg    <= 1'b0;
            prev_reg     <= 1'b0;
            sel_prev_reg <= `ADTF_SEL_NONE;
            rise_o       <= 1'b0;
        end
        else
        begin
            level_reg    <= src_i[sel_i];
            sel_prev_reg <= sel_i;
            // A new selector starts high so its first level is no edge
            prev_reg     <= (sel_prev_reg == sel_i) ? level_reg : 1'b1;
            // Edge only, never level; code 0 disables
            rise_o <= level_reg & ~prev_reg
                      & (sel_prev_reg == sel_i)
                      & (sel_i != `ADTF_SEL_NONE);
        end
    end

endmodule

/* File: verilog/adtf_top.v */
// Purpose: Auto-conversion trigger selection and result justification
// Assumes: Sources on sys_clk_i except the two pins, which are synchronised
// Notes:   Analog conversion is modelled by a cycle count and a result input
`include "adtf_consts.vh"
module adtf_top
(
    input  wire       sys_clk_i,
    input  wire       rst_i,
    input  wire [3:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    input  wire       pwm1_int_i,
    input  wire       pwm2_int_i,
    input  wire       pwm3_int_i,
    input  wire       pwm4_int_i,
    input  wire       pwm1_of_i,
    input  wire       pwm2_of_i,
    input  wire       pwm3_of_i,
    input  wire       pwm4_of_i,
    input  wire       first_timer_overflow_i,
    input  wire       second_timer_overflow_i,
    input  wire       period_timer_match_i,
    input  wire       cmp1_out_i,
    input  wire       cmp2_out_i,
    input  wire       trig_pin_i,
    input  wire       waveform_generator_pin_i,
    input  wire [9:0] conversion_result_i,
    output reg        busy_o,
    output reg        irq_o
);

    reg  [3:0]                start_source_selector_reg;
    reg                       result_justify_select_reg;
    reg                       enable_reg;
    reg  [7:0]                result_high_byte_reg;
    reg  [7:0]                result_low_byte_reg;
    reg  [`ADTF_ST_W-1:0]     status_reg;
    reg  [`ADTF_ST_W-1:0]     mask_reg;
    reg  [`ADTF_ST_W-1:0]     event_next;
    reg  [`ADTF_CNT_W-1:0]    cnt_reg;
    reg  [7:0]                rdata_next;
    reg                       go_req;
    wire [1:0]                pin_sync;
    wire [`ADTF_NUM_SRC-1:0]  src_vec;
    wire                      trig_rise;
    wire                      conv_start;
    wire                      conv_end;
    wire                      wr_ctrl;
    wire                      wr_res_hi;
    wire                      wr_res_lo;
    wire                      wr_status;
    wire [7:0]                trig_rst_val;
    wire [7:0]                ctrl_rst_val;
    wire [31:0]               conv_len_full;
    wire [`ADTF_CNT_W-1:0]    conv_last;
    wire [`ADTF_ST_W-1:0]     pend_vec;
    wire                      trig_event;
    wire                      start_any;

    // Format a result into high and low bytes per justification
    function [15:0] fmt_result;
        input [9:0] res;
        input       right;
        begin
            if (right)
                fmt_result = {6'h00, res[9:8], res[7:0]};
            else
                fmt_result = {res[9:2], res[1:0], 6'h00};
        end
    endfunction

    // Write strobe aimed at one register address
    function wr_hit;
        input [`ADTF_ADDR_W-1:0] a;
        input                    w;
        input [`ADTF_ADDR_W-1:0] target;
        begin
            wr_hit = w && (a == target);
        end
    endfunction

    // Pins cross into the clock domain first
    // The pin paths gain two cycles of latency
    adtf_sync2 #(.W(2)) u_sync
    (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   ({waveform_generator_pin_i, trig_pin_i}),
        .sync_o    (pin_sync)
    );

    // Source table indexed by selector code
    // Index 0 is tied low, so code 0 never fires
    assign src_vec[`ADTF_SEL_NONE]     = 1'b0;
    assign src_vec[`ADTF_SEL_PWM1_INT] = pwm1_int_i;
    assign src_vec[`ADTF_SEL_PWM2_INT] = pwm2_int_i;
    assign src_vec[`ADTF_SEL_T0_OVF]   = first_timer_overflow_i;
    assign src_vec[`ADTF_SEL_T1_OVF]   = second_timer_overflow_i;
    assign src_vec[`ADTF_SEL_PERIOD_TIMER_MATCH] = period_timer_match_i;
    assign src_vec[`ADTF_SEL_CMP1]     = cmp1_out_i;
    assign src_vec[`ADTF_SEL_CMP2]     = cmp2_out_i;
    assign src_vec[`ADTF_SEL_PWM1_OF]  = pwm1_of_i;
    assign src_vec[`ADTF_SEL_PWM2_OF]  = pwm2_of_i;
    assign src_vec[`ADTF_SEL_PWM3_OF]  = pwm3_of_i;
    assign src_vec[`ADTF_SEL_PWM3_INT] = pwm3_int_i;
    assign src_vec[`ADTF_SEL_PWM4_OF]  = pwm4_of_i;
    assign src_vec[`ADTF_SEL_PWM4_INT] = pwm4_int_i;
    assign src_vec[`ADTF_SEL_TRIG_PIN] = pin_sync[0];
    assign src_vec[`ADTF_SEL_WAVE_PIN] = pin_sync[1];

    // Selected source edge detector
    // Rising edges only; a held level never restarts
    adtf_edge_sel u_edge
    (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .src_i     (src_vec),
        .sel_i     (start_source_selector_reg),
        .rise_o    (trig_rise)
    );

    // Register write decodes, shared by several processes
    assign wr_ctrl   = wr_hit(addr_i, wr_i, `ADTF_ADDR_CTRL);
    assign wr_res_hi = wr_hit(addr_i, wr_i, `ADTF_ADDR_RES_HI);
    assign wr_res_lo = wr_hit(addr_i, wr_i, `ADTF_ADDR_RES_LO);
    assign wr_status = wr_hit(addr_i, wr_i, `ADTF_ADDR_STATUS);

    // Reset images and conversion length, sliced to field width
    assign trig_rst_val  = `ADTF_TRIG_RST;
    assign ctrl_rst_val  = `ADTF_CTRL_RST;
    assign conv_len_full = `ADTF_CONV_CYCLES - 1;
    assign conv_last     = conv_len_full[`ADTF_CNT_W-1:0];

    // Software go and trigger edge are equal starts
    always @*
    begin
        go_req = wr_ctrl && wdata_i[`ADTF_CTRL_GO];
    end

    // Either start request, gated below by enable and idle
    assign start_any  = go_req || trig_rise;
    assign conv_start = enable_reg && !busy_o && start_any;
    assign conv_end   = busy_o && (cnt_reg == {`ADTF_CNT_W{1'b0}});

    // Trigger flag only for an edge that really started work
    assign trig_event = trig_rise && conv_start;

    // Control registers, cleared by reset
    // Go is not stored; it only pulses a start
    always @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            start_source_selector_reg <=
                trig_rst_val[`ADTF_SEL_HI:`ADTF_SEL_LO];
            result_justify_select_reg <= ctrl_rst_val[`ADTF_CTRL_JUSTIFY];
            enable_reg                <= ctrl_rst_val[`ADTF_CTRL_ENABLE];
            mask_reg                  <= `ADTF_ST_RST;
        end
        else if (wr_i)
        begin
            case (addr_i)
                `ADTF_ADDR_TRIG:
                    start_source_selector_reg <=
                        wdata_i[`ADTF_SEL_HI:`ADTF_SEL_LO];
                `ADTF_ADDR_CTRL:
                begin
                    result_justify_select_reg <=
                        wdata_i[`ADTF_CTRL_JUSTIFY];
                    enable_reg <= wdata_i[`ADTF_CTRL_ENABLE];
                end
                `ADTF_ADDR_MASK:
                    mask_reg <= wdata_i[`ADTF_ST_W-1:0];
                default:
                    mask_reg <= mask_reg;
            endcase
        end
    end

    // Result bytes: no reset, written by software or conversion end
    // A conversion end beats a software write in the same cycle
    always @(posedge sys_clk_i)
    begin
        if (conv_end)
        begin
            {result_high_byte_reg, result_low_byte_reg} <=
                fmt_result(conversion_result_i,
                           result_justify_select_reg);
        end
        else if (wr_res_hi)
            result_high_byte_reg <= wdata_i;
        else if (wr_res_lo)
            result_low_byte_reg <= wdata_i;
    end

    // Conversion timer
    // Starts while busy are dropped, never queued
    always @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            busy_o  <= 1'b0;
            cnt_reg <= {`ADTF_CNT_W{1'b0}};
        end
        else if (conv_start)
        begin
            busy_o  <= 1'b1;
            cnt_reg <= conv_last;
        end
        else if (conv_end)
            busy_o  <= 1'b0;
        else if (busy_o)
            cnt_reg <= cnt_reg - 1'b1;
    end

    // Events for the sticky status bits
    always @*
    begin
        event_next = {`ADTF_ST_W{1'b0}};
        event_next[`ADTF_ST_DONE]  = conv_end;
        event_next[`ADTF_ST_TRIG]  = trig_event;
        // Overflow sets its flag whether or not it is the start source
        event_next[`ADTF_ST_T0OVF] = first_timer_overflow_i;
        event_next[`ADTF_ST_T1OVF] = second_timer_overflow_i;
    end

    // Status: write one clears, a new event wins over the clear
    // So a clear never loses an event of that same cycle
    always @(posedge sys_clk_i)
    begin
        if (rst_i)
            status_reg <= `ADTF_ST_RST;
        else if (wr_status)
            status_reg <= (status_reg & ~wdata_i[`ADTF_ST_W-1:0])
                          | event_next;
        else
            status_reg <= status_reg | event_next;
    end

    // Pending events seen through the mask
    assign pend_vec = (status_reg | event_next) & mask_reg;

    // Interrupt level registered from the flags and this cycle's events
    // It drops one clock after the flags are cleared
    always @(posedge sys_clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |pend_vec;
    end

    // Read mux, unmapped reads zero
    // Reserved and write-only bits read back as zero
    always @*
    begin
        rdata_next = 8'h00;
        case (addr_i)
            `ADTF_ADDR_TRIG:
                rdata_next = {start_source_selector_reg, 4'h0};
            `ADTF_ADDR_RES_HI:
                rdata_next = result_high_byte_reg;
            `ADTF_ADDR_RES_LO:
                rdata_next = result_low_byte_reg;
            `ADTF_ADDR_CTRL:
            begin
                rdata_next[`ADTF_CTRL_JUSTIFY] = result_justify_select_reg;
                rdata_next[`ADTF_CTRL_ENABLE]  = enable_reg;
                rdata_next[`ADTF_CTRL_BUSY]    = busy_o;
            end
            `ADTF_ADDR_STATUS:
                rdata_next = {4'h0, status_reg};
            `ADTF_ADDR_MASK:
                rdata_next = {4'h0, mask_reg};
            default:
                rdata_next = 8'h00;
        endcase
    end

    // Read data one cycle after the strobe, zero otherwise
    // Zero between reads keeps the port quiet
    always @(posedge sys_clk_i)
    begin
        if (rst_i)
            rdata_o <= 8'h00;
        else if (rd_i)
            rdata_o <= rdata_next;
        else
            rdata_o <= 8'h00;
    end

endmodule

/* File: sim/adtf_chk.sv */
// Purpose: Port checks for the trigger and format block
// Assumes: One clock, reset synchronous and active high
// Notes:   Bound to adtf_top at the foot of this file
module adtf_chk
(
    input logic       sys_clk_i,
    input logic       rst_i,
    input logic [3:0] addr_i,
    input logic [7:0] wdata_i,
    input logic       wr_i,
    input logic       rd_i,
    input logic [7:0] rdata_o,
    input logic       busy_o,
    input logic       irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // Read port answers only in the slot after a strobe
    a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside slot");
    a_sel_low_zero: assert property
        (rd_i && addr_i == 4'h0 |=> rdata_o[3:0] == 4'h0)
        else $error("selector low nibble set");
    a_sel_readback: assert property
        (wr_i && addr_i == 4'h0 ##1 !wr_i ##1 rd_i && addr_i == 4'h0
        |=> rdata_o[7:4] == $past(wdata_i[7:4], 3))
        else $error("selector not kept");
    a_unmapped_zero: assert property
        (rd_i && addr_i > 4'h5 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    // Conversion length and busy visibility
    a_conv_len: assert property
        ($rose(busy_o) |-> busy_o[*8] ##1 busy_o[*3] ##1 !busy_o)
        else $error("conversion length wrong");
    a_ctrl_busy: assert property
        (rd_i && addr_i == 4'h3 |=> rdata_o[3] == $past(busy_o))
        else $error("busy bit disagrees");
    a_rst_idle: assert property
        ($fell(rst_i) |-> !busy_o && !irq_o && rdata_o == 8'h00)
        else $error("outputs active after reset");
    a_mask_off: assert property
        (wr_i && addr_i == 4'h5 && wdata_i == 8'h00 ##1 !wr_i |=> !irq_o)
        else $error("masked interrupt still high");
    c_conv: cover property ($rose(busy_o));
    c_irq: cover property ($rose(irq_o));
    c_rst: cover property ($fell(rst_i));
endmodule

bind adtf_top adtf_chk u_chk
(
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .busy_o(busy_o), .irq_o(irq_o)
);

/* File: sim/adtf_src_model.sv */
// Purpose: Start sources and converter result beside the block
// Assumes: Index of a source equals its selector code
// Notes:   Index 0 is unused; lines change just after an edge
module adtf_src_model
(
    input  logic        sys_clk_i,
    output logic [15:0] src_o,
    output logic [9:0]  res_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial src_o = 16'h0000;
    initial res_o = 10'h000;
    // Set one source level
    task drive(input int k, input logic v);
        @(posedge sys_clk_i);
        src_o[k] <= v;
    endtask
    // One-cycle event, low again just after the next edge
    task pulse(input int k);
        drive(k, 1'b1);
        drive(k, 1'b0);
    endtask
    // Value the converter delivers at the end
    task put_res(input logic [9:0] v);
        @(posedge sys_clk_i);
        res_o <= v;
    endtask
endmodule

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for adtf_top
// Assumes: 20 MHz clock, register port with one-cycle strobes
// Notes:   Sources come from adtf_src_model
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  addr_i = 4'h0;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [7:0]  rdata_o;
    logic [7:0]  rv;
    logic        busy_o;
    logic        irq_o;
    logic [15:0] s;
    logic [9:0]  cr;
    logic [9:0]  res;
    int          err_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          k;
    adtf_src_model model (.sys_clk_i(sys_clk_i), .src_o(s), .res_o(cr));
    adtf_top uut
    (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .pwm1_int_i(s[1]), .pwm2_int_i(s[2]), .pwm3_int_i(s[11]),
        .pwm4_int_i(s[13]), .pwm1_of_i(s[8]), .pwm2_of_i(s[9]),
        .pwm3_of_i(s[10]), .pwm4_of_i(s[12]),
        .first_timer_overflow_i(s[3]), .second_timer_overflow_i(s[4]),
        .period_timer_match_i(s[5]), .cmp1_out_i(s[6]),
        .cmp2_out_i(s[7]), .trig_pin_i(s[14]),
        .waveform_generator_pin_i(s[15]), .conversion_result_i(cr),
        .busy_o(busy_o), .irq_o(irq_o)
    );
    always #25 sys_clk_i = ~sys_clk_i;
    // Cut a hang short
    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            complete_run();
        end
    end
    task chk(input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want)
        begin
            err_count++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task rchk(input logic [3:0] a, input logic [7:0] want);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, want);
    endtask
    // Wait for a start, or its absence, then for the end
    task watch(input logic want);
        int n;
        n = 0;
        while (busy_o !== 1'b1 && n < 8)
        begin
            @(posedge sys_clk_i);
            #1 n++;
        end
        chk({7'h00, busy_o}, {7'h00, want});
        while (busy_o !== 1'b0 && n < 40)
        begin
            @(posedge sys_clk_i);
            #1 n++;
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rchk(4'h0, 8'h00);
        wr(4'h0, 8'hFF);
        rchk(4'h0, 8'hF0);
        rchk(4'h9, 8'h00);
        wr(4'h5, 8'h01);
        $display("test reset done");
        // Every nonzero selector code, justification alternating
        for (k = 1; k < 16; k++)
        begin
            res = 10'(10'h2A5 ^ (k * 77));
            model.put_res(res);
            wr(4'h3, {7'h01, k[0]});
            wr(4'h0, {k[3:0], 4'h0});
            model.pulse(k);
            watch(1'b1);
            chk({7'h00, irq_o}, 8'h01);
            rchk(4'h4, k == 3 ? 8'h07 : k == 4 ? 8'h0B : 8'h03);
            if (k[0])
            begin
                rchk(4'h1, {6'h00, res[9:8]});
                rchk(4'h2, res[7:0]);
            end
            else
            begin
                rchk(4'h1, res[9:2]);
                rchk(4'h2, {res[1:0], 6'h00});
            end
            wr(4'h4, 8'h0F);
            @(posedge sys_clk_i);
            #1 chk({7'h00, irq_o}, 8'h00);
        end
        $display("test sources done");
        // Selector zero, disabled, and a held level
        wr(4'h0, 8'h00);
        model.pulse(5);
        watch(1'b0);
        wr(4'h3, 8'h00);
        wr(4'h0, 8'h50);
        model.pulse(5);
        watch(1'b0);
        wr(4'h3, 8'h02);
        model.drive(5, 1'b1);
        repeat (4) @(posedge sys_clk_i);
        rchk(4'h3, 8'h0A);
        watch(1'b1);
        watch(1'b0);
        model.drive(5, 1'b0);
        wr(4'h5, 8'h00);
        @(posedge sys_clk_i);
        #1 chk({7'h00, irq_o}, 8'h00);
        rchk(4'h4, 8'h03);
        wr(4'h4, 8'h0F);
        rchk(4'h4, 8'h00);
        $display("test gating done");
        // Software go starts a conversion, no trigger flag
        wr(4'h3, 8'h06);
        watch(1'b1);
        rchk(4'h4, 8'h01);
        rchk(4'h1, res[9:2]);
        wr(4'h4, 8'h0F);
        $display("test go done");
        // Result bytes survive a reset
        wr(4'h1, 8'h5A);
        wr(4'h2, 8'hC3);
        rchk(4'h1, 8'h5A);
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rchk(4'h1, 8'h5A);
        rchk(4'h2, 8'hC3);
        rchk(4'h0, 8'h00);
        $display("test reset keep done");
        complete_run();
    end
endmodule
